// ---- rtl/ctp_pkg.sv ----
package ctp_pkg;
  // Register byte addresses
  localparam logic [7:0]  CTP_CTRL_ADDR    = 8'h9C; // 0x27 * 4
  localparam logic [7:0]  CTP_EXT_ADDR     = 8'hA0; // Holds 100Base-TX top bit
  localparam logic [7:0]  CTP_SPEED_ADDR   = 8'hA4; // Speed force and mode
  localparam logic [7:0]  CTP_STAT_ADDR    = 8'hA8; // Line state readback
  localparam logic [7:0]  CTP_CTRL_INDEX   = 8'h27;
  // Field positions
  localparam int          CTP_EN_BIT       = 4;
  localparam int          CTP_EXT_BIT      = 5;
  localparam int          CTP_FORCE_BIT    = 0;
  localparam int          CTP_SPD100_BIT   = 1;
  localparam int          CTP_TX_MODE_BIT  = 2;
  // Reset values
  localparam logic [15:0] CTP_CTRL_RST     = 16'h0000;
  // Pattern codes
  localparam logic [3:0]  CTP_P_NLP        = 4'h0;
  localparam logic [3:0]  CTP_P_ONE        = 4'h1;
  localparam logic [3:0]  CTP_P_ZERO       = 4'h2;
  localparam logic [3:0]  CTP_P_REP1       = 4'h3;
  localparam logic [3:0]  CTP_P_REP0       = 4'h4;
  localparam logic [3:0]  CTP_P_PREAMBLE   = 4'h5;
  localparam logic [3:0]  CTP_P_ONE_IDLE   = 4'h6;
  localparam logic [3:0]  CTP_P_ZERO_IDLE  = 4'h7;
  localparam logic [3:0]  CTP_P_1001       = 4'h8;
  localparam logic [3:0]  CTP_P_RANDOM     = 4'h9;
  localparam logic [3:0]  CTP_P_IDLE00     = 4'hA;
  localparam logic [3:0]  CTP_P_IDLE01     = 4'hB;
  localparam logic [3:0]  CTP_P_IDLE11     = 4'hC;
  // Line symbol encoding on tx_sym
  localparam logic [1:0]  CTP_SYM_IDLE     = 2'h0;
  localparam logic [1:0]  CTP_SYM_ONE      = 2'h1;
  localparam logic [1:0]  CTP_SYM_ZERO     = 2'h2;
  localparam logic [1:0]  CTP_SYM_NLP      = 2'h3;
  // Bit time: 100 ns at 10 Mb/s, 10 ns clock
  localparam int          CTP_CLK_NS       = 10;
  localparam int          CTP_BIT_NS       = 100;
  localparam int          CTP_BIT_CYC      = (CTP_BIT_NS + CTP_CLK_NS - 1) / CTP_CLK_NS;
  localparam logic [15:0] CTP_LFSR_SEED    = 16'hACE1;
endpackage

// ---- rtl/ctp_top.sv ----
// Implementation choice: register access over AHB-Lite.
module ctp_top
  import ctp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [1:0]  tx_sym,
  output logic             tx_active,
  output logic             tx100_bit
);

  typedef enum logic [1:0] {CTP_RUN, CTP_SINGLE, CTP_HOLD_IDLE} ctp_phase_type;

  logic [15:0]   ctrl_q;
  logic          ext_q;
  logic [2:0]    speed_q;
  logic          wr_q;
  logic [7:0]    addr_q;
  logic [3:0]    bit_cnt_q;
  logic          bit_tick;
  logic [3:0]    cfg_prev_q;
  logic          en_prev_q;
  logic [1:0]    seq_q;
  ctp_phase_type phase_q;
  logic [15:0]   lfsr_q;
  logic [31:0]   shift_q;
  logic [4:0]    zeros_q;
  logic [4:0]    tx100_val;
  logic          restart;
  logic [1:0]    sym_d;

  // Address decode used on the read path
  function automatic logic is_reg(input logic [7:0] a);
    return (a == CTP_CTRL_ADDR) || (a == CTP_EXT_ADDR) ||
           (a == CTP_SPEED_ADDR) || (a == CTP_STAT_ADDR);
  endfunction

  // Bus address phase capture, zero wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q   <= hsel && htrans[1] && hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Register writes, full word only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= CTP_CTRL_RST;
      ext_q   <= 1'b0;
      speed_q <= 3'h0;
    end else if (wr_q) begin
      if (addr_q == CTP_CTRL_ADDR)  ctrl_q  <= hwdata[15:0];
      if (addr_q == CTP_EXT_ADDR)   ext_q   <= hwdata[CTP_EXT_BIT];
      if (addr_q == CTP_SPEED_ADDR) speed_q <= hwdata[2:0];
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h0000_0000;
      if (is_reg(haddr[7:0])) begin
        case (haddr[7:0])
          CTP_CTRL_ADDR:  hrdata <= {16'h0000, ctrl_q};
          CTP_EXT_ADDR:   hrdata <= {26'h0, ext_q, 5'h00};
          CTP_SPEED_ADDR: hrdata <= {29'h0, speed_q};
          // Status: shift register low byte, test bit, symbol
          default:        hrdata <= {21'h0, shift_q[7:0], tx100_bit, tx_sym};
        endcase
      end
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Bit time enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt_q <= 4'h0;
    end else if (bit_tick || restart) begin
      bit_cnt_q <= 4'h0; // Restart aligns a full first bit time
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end
  assign bit_tick = (bit_cnt_q == 4'(CTP_BIT_CYC - 1));

  // Restart sequence when enable or code changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_prev_q <= 4'h0;
      en_prev_q  <= 1'b0;
    end else begin
      cfg_prev_q <= ctrl_q[3:0];
      en_prev_q  <= ctrl_q[CTP_EN_BIT];
    end
  end
  assign restart = (cfg_prev_q != ctrl_q[3:0]) || (en_prev_q != ctrl_q[CTP_EN_BIT]);

  // Random data source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfsr_q <= CTP_LFSR_SEED;
    end else if (bit_tick) begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // Sequence position and single-shot phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_q   <= 2'h0;
      phase_q <= CTP_SINGLE;
    end else if (restart) begin
      seq_q   <= 2'h0;
      phase_q <= CTP_SINGLE;
    end else if (bit_tick) begin
      seq_q <= seq_q + 2'h1;
      case (phase_q)
        CTP_SINGLE:    phase_q <= CTP_HOLD_IDLE;
        CTP_HOLD_IDLE: phase_q <= CTP_HOLD_IDLE;
        default:       phase_q <= CTP_RUN;
      endcase
    end
  end

  // Pattern symbol selection
  always_comb begin
    sym_d = CTP_SYM_IDLE;
    // Idle during restart so no short stale symbol leaks out
    if (ctrl_q[CTP_EN_BIT] && !speed_q[CTP_TX_MODE_BIT] && !restart) begin
      case (ctrl_q[3:0])
        CTP_P_NLP:  sym_d = (phase_q == CTP_SINGLE) ? CTP_SYM_NLP : CTP_SYM_IDLE;
        CTP_P_ONE:  sym_d = (phase_q == CTP_SINGLE) ? CTP_SYM_ONE : CTP_SYM_IDLE;
        CTP_P_ZERO: sym_d = (phase_q == CTP_SINGLE) ? CTP_SYM_ZERO : CTP_SYM_IDLE;
        CTP_P_REP1: sym_d = CTP_SYM_ONE;
        CTP_P_REP0: sym_d = CTP_SYM_ZERO;
        CTP_P_PREAMBLE: sym_d = seq_q[0] ? CTP_SYM_ZERO : CTP_SYM_ONE;
        CTP_P_ONE_IDLE:  sym_d = (phase_q == CTP_SINGLE) ? CTP_SYM_ONE : CTP_SYM_IDLE;
        CTP_P_ZERO_IDLE: sym_d = (phase_q == CTP_SINGLE) ? CTP_SYM_ZERO : CTP_SYM_IDLE;
        CTP_P_1001: sym_d = (seq_q == 2'h0 || seq_q == 2'h3) ? CTP_SYM_ONE : CTP_SYM_ZERO;
        CTP_P_RANDOM: sym_d = lfsr_q[0] ? CTP_SYM_ONE : CTP_SYM_ZERO;
        CTP_P_IDLE00: sym_d = CTP_SYM_IDLE;
        CTP_P_IDLE01: sym_d = seq_q[0] ? CTP_SYM_ONE : CTP_SYM_ZERO;
        CTP_P_IDLE11: sym_d = CTP_SYM_ONE;
        default:    sym_d = CTP_SYM_IDLE;
      endcase
    end
  end

  // Registered 10Base-Te line outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sym    <= CTP_SYM_IDLE;
      tx_active <= 1'b0;
    end else begin
      tx_sym    <= sym_d;
      tx_active <= (sym_d != CTP_SYM_IDLE);
    end
  end

  // 100Base-TX one followed by N zeros
  assign tx100_val = {ext_q, ctrl_q[3:0]};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q   <= 32'h0000_0000;
      zeros_q   <= 5'h00;
      tx100_bit <= 1'b0;
    end else if (!speed_q[CTP_TX_MODE_BIT] || tx100_val == 5'h00) begin
      shift_q   <= 32'h0000_0000;
      zeros_q   <= 5'h00;
      tx100_bit <= 1'b0;
    end else if (zeros_q == 5'h00) begin
      tx100_bit <= 1'b1;
      zeros_q   <= tx100_val;
      shift_q   <= {shift_q[30:0], 1'b1};
    end else begin
      tx100_bit <= 1'b0;
      zeros_q   <= zeros_q - 5'h01;
      shift_q   <= {shift_q[30:0], 1'b0};
    end
  end

endmodule

// ---- verif/compliance_test_pattern_select_tb.sv ----
module compliance_test_pattern_select_tb;
  import ctp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 2'h0, tx_sym;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic        hreadyout, hresp, tx_active, tx100_bit;
  int          bad_count = 0, samples_checked = 0, nsym, n0;
  logic [1:0]  s1 [13] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1,
                           2'h0, 2'h0, 2'h2, 2'h1};
  logic [1:0]  s2 [13] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h2,
                           2'h0, 2'h0, 2'h1, 2'h1};
  ctp_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_sym, .tx_active, .tx100_bit);
  ctp_line_mon i_mon (.hclk, .tx_sym, .nsym);
  initial forever #5 hclk = ~hclk;
  // One single transfer, waits on ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Waits for a one, then n zeros and a one
  task automatic tx100(input int n);
    int k = 0;
    while (tx100_bit !== 1'b1 && k < 60) begin
      @(posedge hclk);
      k++;
    end
    for (k = 0; k <= n; k++) begin
      @(posedge hclk);
      chk(k == n, tx100_bit);
    end
  endtask
  task automatic close_out;
    $display("checked %0d wrong %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, CTP_CTRL_ADDR, 0);
    chk(CTP_CTRL_RST, r);
    bus(1, CTP_CTRL_ADDR, 32'h1F);
    bus(0, CTP_CTRL_ADDR, 0);
    chk(32'h1F, r);
    bus(0, 8'hFC, 0);
    chk(0, r);
    $display("test regs done");
    bus(1, CTP_SPEED_ADDR, 32'h1);
    bus(1, CTP_CTRL_ADDR, 32'h3);
    n0 = nsym;
    repeat (30) @(posedge hclk);
    bus(0, CTP_STAT_ADDR, 0);
    chk(0, r);
    chk(n0, nsym);
    $display("test disable done");
    for (int c = 0; c < 13; c++) begin
      bus(1, CTP_CTRL_ADDR, 0);
      repeat (20) @(posedge hclk);
      bus(1, CTP_CTRL_ADDR, 32'h10 | c);
      repeat (2) @(posedge hclk);
      bus(0, CTP_STAT_ADDR, 0);
      if (c != 9) chk(s1[c], r[1:0]);
      repeat (8) @(posedge hclk);
      bus(0, CTP_STAT_ADDR, 0);
      if (c != 9) chk(s2[c], r[1:0]);
    end
    $display("test codes done");
    bus(1, CTP_CTRL_ADDR, 0);
    bus(1, CTP_SPEED_ADDR, 32'h7);
    bus(1, CTP_CTRL_ADDR, 32'h3);
    tx100(3);
    bus(1, CTP_EXT_ADDR, 32'h20);
    bus(1, CTP_CTRL_ADDR, 32'h2);
    tx100(18);
    bus(1, CTP_EXT_ADDR, 0);
    bus(1, CTP_CTRL_ADDR, 0);
    repeat (4) @(posedge hclk);
    repeat (25) @(posedge hclk) chk(0, tx100_bit);
    bus(0, CTP_STAT_ADDR, 0);
    chk(0, r[10:3]);
    $display("test 100tx done");
    close_out;
  end
  // Watchdog
  initial begin
    #50000;
    bad_count++;
    close_out;
  end
endmodule

// ---- verif/ctp_chk_sva.sv ----
module ctp_chk (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  input logic [1:0]  tx_sym,
  input logic        tx_active,
  input logic        tx100_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bus answers
  a_ready_high: assert property (hreadyout) else $error("ready low");
  a_resp_okay: assert property (!hresp) else $error("resp not okay");
  a_phase_done: assert property (hsel && htrans[1] && hready |=> hreadyout && !hresp)
    else $error("data phase stalled");
  a_rdata_hold: assert property (!$past(hsel && htrans[1] && !hwrite && hready)
    |-> $stable(hrdata)) else $error("read data moved");
  // Line behaviour
  a_active_match: assert property (tx_active == (tx_sym != 2'h0))
    else $error("active flag wrong");
  a_sym_hold: assert property ($changed(tx_sym) && tx_sym != 2'h0
    |=> (tx_sym == 2'h0 || $stable(tx_sym))[*8]) else $error("symbol too short");
  a_nlp_single: assert property ($rose(tx_sym == 2'h3) |-> ##[9:11] tx_sym != 2'h3)
    else $error("link pulse repeats");
  a_tx100_sparse: assert property (tx100_bit |=> !tx100_bit)
    else $error("two ones in a row");
  c_nlp: cover property (tx_sym == 2'h3);
  c_tx100: cover property (tx100_bit);
  c_start: cover property ($rose(tx_active));
endmodule
bind ctp_top ctp_chk i_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .tx_sym, .tx_active, .tx100_bit);

// ---- verif/ctp_line_mon.sv ----
module ctp_line_mon (
  input logic       hclk,
  input logic [1:0] tx_sym,
  output int        nsym
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] last_q = 2'h0;
  int         n_q    = 0;
  assign nsym = n_q;
  // Test set counts symbol starts
  always @(posedge hclk) begin
    if (tx_sym != last_q && tx_sym != 2'h0) n_q <= n_q + 1;
    last_q <= tx_sym;
  end
endmodule
